/* File: pkg/bwp_pkg.sv */
package bwp_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned STROBE_US = 100;
    localparam int unsigned STROBE_CYC = (CLK_HZ / 1_000_000) * STROBE_US;
    localparam int unsigned DEBOUNCE_US = 1000;
    localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;

    // value layout
    localparam int unsigned DIGITS = 5;
    localparam int unsigned MAG_W = 20;
    localparam int unsigned BCD_W = 4 * DIGITS;
    localparam int unsigned CONV_DIGITS = 7;
    localparam logic [19:0] TARE_LIMIT = 20'hF_423F;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_NET_OVER = 5'h04;
    localparam logic [4:0] OFS_GROSS_OVER = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_MASK = 5'h10;
    localparam logic [4:0] OFS_PORT = 5'h14;
    localparam logic [4:0] OFS_INPUTS = 5'h18;

    // control fields
    localparam int unsigned CTRL_SKIP_LSB = 0;
    localparam int unsigned CTRL_SKIP_W = 4;
    localparam logic [3:0] CTRL_SKIP_RST = 4'h0;
    localparam logic [19:0] NET_OVER_RST = 20'h1_869F;
    localparam logic [19:0] GROSS_OVER_RST = 20'h1_869F;

    // status and mask bits
    localparam int unsigned ST_UPDATE = 0;
    localparam int unsigned ST_PRINT = 1;
    localparam int unsigned ST_OVER = 2;
    localparam int unsigned ST_W = 3;
    localparam logic [2:0] MASK_RST = 3'h0;

    // port register fields
    localparam int unsigned PORT_MINUS = 20;
    localparam int unsigned PORT_OVER = 21;

    // value selection
    typedef enum logic [1:0] {
        BWP_SEL_DISP,
        BWP_SEL_NET,
        BWP_SEL_GROSS,
        BWP_SEL_TARE
    } bwp_sel_t;

    typedef enum logic [1:0] {
        BWP_IDLE,
        BWP_CONV,
        BWP_STRB
    } bwp_state_t;
endpackage

/* File: verilog/bwp_sync.sv */
// two-flop synchroniser plus debounce for slow contact inputs
module bwp_sync #(
    parameter int unsigned W = 4,
    parameter int unsigned DEB_CYC = 20000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // raw pins and clean levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] clean
);
    localparam int unsigned CW = $clog2(DEB_CYC + 1);

    initial begin
        if (DEB_CYC < 1) begin
            $error("debounce count must be at least one");
        end
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1_q, s2_q, cl_q, cl_d;
        logic [CW-1:0] cnt_q, cnt_d;

        // count while the synchronised level differs
        always_comb begin
            cl_d = cl_q;
            cnt_d = '0;
            if (s2_q != cl_q) begin
                if (cnt_q == CW'(DEB_CYC - 1)) begin
                    cl_d = s2_q;
                end else begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
        end

        // open contact idles high
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                s1_q <= 1'b1;
                s2_q <= 1'b1;
                cl_q <= 1'b1;
                cnt_q <= '0;
            end else begin
                s1_q <= raw[i];
                s2_q <= s1_q;
                cl_q <= cl_d;
                cnt_q <= cnt_d;
            end
        end

        assign clean[i] = cl_q;
    end
endmodule

/* File: verilog/bwp_port.sv */
// What this block does
// - Five decimal digits go out, each as four lines weighted 8, 4, 2, 1 in plain binary.
// - The sign line is 0 for a positive value and 1 for a negative one.
// - The over line is 1 when net beats its limit, gross beats its limit or tare beats 999999.
// - A print pulse goes out with each completion of the over/under comparison made while hold is open.
// - Digits refresh after each conversion and one strobe pulse marks each refreshed set.
// - By default every conversion updates the port; a setting skips conversions to slow it.
// - While hold is shorted the data lines freeze and no strobe goes out.
// - Polarity input open gives negative logic, shorted gives positive logic.
// - Negative logic turns the transistor on for a 1; positive logic turns it off for a 1.
// - The two selection inputs pick displayed, net, gross or tare value.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
module bwp_port #(
    parameter int unsigned DEB_CYC = bwp_pkg::DEBOUNCE_CYC,
    parameter int unsigned STRB_CYC = bwp_pkg::STROBE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // weighing core
    input wire logic adc_done,
    input wire logic judge_done,
    input wire logic [19:0] disp_mag,
    input wire logic disp_neg,
    input wire logic disp_over,
    input wire logic [19:0] net_mag,
    input wire logic net_neg,
    input wire logic [19:0] gross_mag,
    input wire logic gross_neg,
    input wire logic [19:0] tare_mag,
    input wire logic tare_neg,
    // contact inputs, low while shorted to common_return
    input wire logic hold_pin_n,
    input wire logic logic_pin_n,
    input wire logic sel1_pin_n,
    input wire logic sel2_pin_n,
    // open-collector drives, high turns the transistor on
    output logic [19:0] bcd_sink,
    output logic minus_sink,
    output logic over_sink,
    output logic pc_sink,
    output logic strobe_sink
);
    localparam int unsigned SCW = $clog2(STRB_CYC + 1);
    localparam int unsigned DW = 4 * bwp_pkg::CONV_DIGITS;
    localparam int unsigned BITS = bwp_pkg::MAG_W;

    initial begin
        if (STRB_CYC < 2 || DEB_CYC < 1) begin
            $error("pulse and debounce counts too small");
        end
    end

    // one add-3 pass over every digit of the conversion register
    function automatic logic [DW-1:0] add3(input logic [DW-1:0] v);
        logic [DW-1:0] r;
        r = v;
        for (int k = 0; k < bwp_pkg::CONV_DIGITS; k++) begin
            if (r[4*k +: 4] > 4'h4) begin
                r[4*k +: 4] = r[4*k +: 4] + 4'h3;
            end
        end
        return r;
    endfunction

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
                r[8*k +: 8] = nw[8*k +: 8];
            end
        end
        return r;
    endfunction

    // contact inputs, synchronised and debounced
    logic [3:0] pins_clean;
    bwp_sync #(
        .W(4),
        .DEB_CYC(DEB_CYC)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .raw({hold_pin_n, logic_pin_n, sel1_pin_n, sel2_pin_n}),
        .clean(pins_clean)
    );

    logic hold_act, pos_logic;
    bwp_pkg::bwp_sel_t sel;
    assign hold_act = !pins_clean[3];
    assign pos_logic = !pins_clean[2];

    // selection decode
    always_comb begin
        unique case (pins_clean[1:0])
            2'b11: sel = bwp_pkg::BWP_SEL_DISP;
            2'b10: sel = bwp_pkg::BWP_SEL_NET;
            2'b00: sel = bwp_pkg::BWP_SEL_GROSS;
            2'b01: sel = bwp_pkg::BWP_SEL_TARE;
        endcase
    end

    // register state
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [3:0] skip_cfg_q, skip_cfg_d;
    logic [19:0] net_lim_q, net_lim_d, gross_lim_q, gross_lim_d;
    logic [2:0] status_q, status_d, mask_q, mask_d;
    logic [2:0] ev;

    // pipeline state
    bwp_pkg::bwp_state_t st_q, st_d;
    logic [3:0] skip_q, skip_d;
    logic [19:0] bin_q, bin_d;
    logic [DW-1:0] dig_q, dig_d;
    logic [DW-1:0] dig_adj;
    logic [4:0] bit_q, bit_d;
    logic cap_neg_q, cap_neg_d, cap_over_q, cap_over_d;
    logic [19:0] bcd_q, bcd_d;
    logic minus_q, minus_d, over_q, over_d;
    logic strb_q, strb_d, pc_q, pc_d;
    logic [SCW-1:0] scnt_q, scnt_d, pcnt_q, pcnt_d;
    logic start;
    logic [19:0] sel_mag;
    logic sel_neg, sel_over;

    // value picked by the selection inputs
    always_comb begin
        unique case (sel)
            bwp_pkg::BWP_SEL_DISP: begin
                sel_mag = disp_mag;
                sel_neg = disp_neg;
                sel_over = disp_over;
            end
            bwp_pkg::BWP_SEL_NET: begin
                sel_mag = net_mag;
                sel_neg = net_neg;
                sel_over = !net_neg && (net_mag > net_lim_q);
            end
            bwp_pkg::BWP_SEL_GROSS: begin
                sel_mag = gross_mag;
                sel_neg = gross_neg;
                sel_over = !gross_neg && (gross_mag > gross_lim_q);
            end
            bwp_pkg::BWP_SEL_TARE: begin
                sel_mag = tare_mag;
                sel_neg = tare_neg;
                sel_over = !tare_neg && (tare_mag > bwp_pkg::TARE_LIMIT);
            end
        endcase
    end

    // conversion taken when idle, not held and the skip count is spent
    assign start = adc_done && !hold_act && st_q == bwp_pkg::BWP_IDLE && skip_q == 4'h0;

    // digits after the add-3 pass, before the shift
    assign dig_adj = add3(dig_q);

    // update pipeline: capture, binary to bcd, strobe
    always_comb begin
        st_d = st_q;
        skip_d = skip_q;
        bin_d = bin_q;
        dig_d = dig_q;
        bit_d = bit_q;
        cap_neg_d = cap_neg_q;
        cap_over_d = cap_over_q;
        bcd_d = bcd_q;
        minus_d = minus_q;
        over_d = over_q;
        strb_d = strb_q;
        scnt_d = scnt_q;
        if (adc_done && st_q == bwp_pkg::BWP_IDLE && !hold_act) begin
            skip_d = (skip_q == 4'h0) ? skip_cfg_q : skip_q - 4'h1;
        end
        unique case (st_q)
            bwp_pkg::BWP_IDLE: begin
                if (start) begin
                    bin_d = sel_mag;
                    dig_d = '0;
                    bit_d = '0;
                    cap_neg_d = sel_neg;
                    cap_over_d = sel_over;
                    st_d = bwp_pkg::BWP_CONV;
                end
            end
            bwp_pkg::BWP_CONV: begin
                dig_d = {dig_adj[DW-2:0], bin_q[19]};
                bin_d = {bin_q[18:0], 1'b0};
                bit_d = bit_q + 5'h1;
                if (bit_q == 5'(BITS - 1)) begin
                    st_d = bwp_pkg::BWP_STRB;
                end
            end
            bwp_pkg::BWP_STRB: begin
                if (hold_act) begin
                    st_d = bwp_pkg::BWP_IDLE;
                    strb_d = 1'b0;
                end else if (!strb_q) begin
                    bcd_d = dig_q[bwp_pkg::BCD_W-1:0];
                    minus_d = cap_neg_q;
                    over_d = cap_over_q;
                    strb_d = 1'b1;
                    scnt_d = SCW'(STRB_CYC - 1);
                end else if (scnt_q == '0) begin
                    strb_d = 1'b0;
                    st_d = bwp_pkg::BWP_IDLE;
                end else begin
                    scnt_d = scnt_q - SCW'(1);
                end
            end
        endcase
    end

    // print pulse on each comparison completion, suppressed while held
    always_comb begin
        pc_d = pc_q;
        pcnt_d = pcnt_q;
        if (hold_act) begin
            pc_d = 1'b0;
        end else if (judge_done) begin
            pc_d = 1'b1;
            pcnt_d = SCW'(STRB_CYC - 1);
        end else if (pc_q) begin
            if (pcnt_q == '0) begin
                pc_d = 1'b0;
            end else begin
                pcnt_d = pcnt_q - SCW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= bwp_pkg::BWP_IDLE;
            skip_q <= '0;
            bin_q <= '0;
            dig_q <= '0;
            bit_q <= '0;
            cap_neg_q <= 1'b0;
            cap_over_q <= 1'b0;
            bcd_q <= '0;
            minus_q <= 1'b0;
            over_q <= 1'b0;
            strb_q <= 1'b0;
            scnt_q <= '0;
            pc_q <= 1'b0;
            pcnt_q <= '0;
        end else begin
            st_q <= st_d;
            skip_q <= skip_d;
            bin_q <= bin_d;
            dig_q <= dig_d;
            bit_q <= bit_d;
            cap_neg_q <= cap_neg_d;
            cap_over_q <= cap_over_d;
            bcd_q <= bcd_d;
            minus_q <= minus_d;
            over_q <= over_d;
            strb_q <= strb_d;
            scnt_q <= scnt_d;
            pc_q <= pc_d;
            pcnt_q <= pcnt_d;
        end
    end

    // transistor drive: data xor logic sense
    assign bcd_sink = bcd_q ^ {20{pos_logic}};
    assign minus_sink = minus_q ^ pos_logic;
    assign over_sink = over_q ^ pos_logic;
    assign strobe_sink = strb_q ^ pos_logic;
    assign pc_sink = pc_q ^ pos_logic;

    // events for the status register
    assign ev[bwp_pkg::ST_UPDATE] = strb_d && !strb_q;
    assign ev[bwp_pkg::ST_PRINT] = pc_d && !pc_q;
    assign ev[bwp_pkg::ST_OVER] = over_d && !over_q;

    // bus slave: one wait cycle, then answer
    always_comb begin
        logic [31:0] wv;
        wv = '0;
        ack_d = (avs_read || avs_write) && !ack_q;
        rdata_d = rdata_q;
        skip_cfg_d = skip_cfg_q;
        net_lim_d = net_lim_q;
        gross_lim_d = gross_lim_q;
        mask_d = mask_q;
        status_d = status_q;
        if (ack_d && avs_read) begin
            unique case (avs_address)
                bwp_pkg::OFS_CTRL: rdata_d = {28'h000_0000, skip_cfg_q};
                bwp_pkg::OFS_NET_OVER: rdata_d = {12'h000, net_lim_q};
                bwp_pkg::OFS_GROSS_OVER: rdata_d = {12'h000, gross_lim_q};
                bwp_pkg::OFS_STATUS: rdata_d = {29'h0000_0000, status_q};
                bwp_pkg::OFS_MASK: rdata_d = {29'h0000_0000, mask_q};
                bwp_pkg::OFS_PORT: rdata_d = {10'h000, over_q, minus_q, bcd_q};
                bwp_pkg::OFS_INPUTS: rdata_d = {28'h000_0000, pins_clean};
                default: rdata_d = '0;
            endcase
        end
        if (ack_q && avs_write) begin
            unique case (avs_address)
                bwp_pkg::OFS_CTRL: begin
                    wv = merge({28'h000_0000, skip_cfg_q}, avs_writedata, avs_byteenable);
                    skip_cfg_d = wv[bwp_pkg::CTRL_SKIP_LSB +: bwp_pkg::CTRL_SKIP_W];
                end
                bwp_pkg::OFS_NET_OVER: begin
                    wv = merge({12'h000, net_lim_q}, avs_writedata, avs_byteenable);
                    net_lim_d = wv[19:0];
                end
                bwp_pkg::OFS_GROSS_OVER: begin
                    wv = merge({12'h000, gross_lim_q}, avs_writedata, avs_byteenable);
                    gross_lim_d = wv[19:0];
                end
                bwp_pkg::OFS_STATUS: begin
                    if (avs_byteenable[0]) begin
                        status_d = status_q & ~avs_writedata[2:0];
                    end
                end
                bwp_pkg::OFS_MASK: begin
                    if (avs_byteenable[0]) begin
                        mask_d = avs_writedata[2:0];
                    end
                end
                default: wv = '0;
            endcase
        end
        status_d = status_d | ev; // set wins over clear
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            skip_cfg_q <= bwp_pkg::CTRL_SKIP_RST;
            net_lim_q <= bwp_pkg::NET_OVER_RST;
            gross_lim_q <= bwp_pkg::GROSS_OVER_RST;
            status_q <= '0;
            mask_q <= bwp_pkg::MASK_RST;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            skip_cfg_q <= skip_cfg_d;
            net_lim_q <= net_lim_d;
            gross_lim_q <= gross_lim_d;
            status_q <= status_d;
            mask_q <= mask_d;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rdata_q;
    assign irq = |(status_q & mask_q);

    // checks
    property p_digits;
        @(posedge clk) disable iff (!rst_n)
        bcd_q[3:0] <= 4'h9 && bcd_q[7:4] <= 4'h9 && bcd_q[11:8] <= 4'h9
            && bcd_q[15:12] <= 4'h9 && bcd_q[19:16] <= 4'h9;
    endproperty
    a_digits: assert property (p_digits) else $error("bcd digit above nine");

    property p_sign;
        @(posedge clk) disable iff (!rst_n)
        start |-> ##22 (minus_q == $past(sel_neg, 22) || hold_act || $past(hold_act));
    endproperty
    a_sign: assert property (p_sign) else $error("sign not from captured value");

    property p_tare_over;
        @(posedge clk) disable iff (!rst_n)
        start && sel == bwp_pkg::BWP_SEL_TARE && !tare_neg && tare_mag > bwp_pkg::TARE_LIMIT
            |=> cap_over_q;
    endproperty
    a_tare_over: assert property (p_tare_over) else $error("tare over missed");

    property p_print;
        @(posedge clk) disable iff (!rst_n)
        judge_done && !hold_act |=> pc_q ##1 (pc_q || $past(hold_act));
    endproperty
    a_print: assert property (p_print) else $error("print pulse missing");

    property p_strobe_after;
        @(posedge clk) disable iff (!rst_n)
        start |-> ##22 (strb_q || $past(hold_act));
    endproperty
    a_strobe_after: assert property (p_strobe_after) else $error("strobe late");

    property p_strobe_len;
        @(posedge clk) disable iff (!rst_n)
        $rose(strb_q) |-> ##1 (strb_q || hold_act) [*8];
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");

    // cycles the strobe has stood high
    logic [SCW-1:0] shi_q, shi_d;
    always_comb begin
        shi_d = strb_q ? shi_q + SCW'(1) : '0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shi_q <= '0;
        end else begin
            shi_q <= shi_d;
        end
    end

    property p_strobe_end;
        @(posedge clk) disable iff (!rst_n)
        strb_q |-> shi_q < SCW'(STRB_CYC);
    endproperty
    a_strobe_end: assert property (p_strobe_end) else $error("strobe never ends");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        hold_act && $past(hold_act) |-> $stable(bcd_q) && !$rose(strb_q);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved while held");

    property p_pol;
        @(posedge clk) disable iff (!rst_n)
        pins_clean[2] && strb_q |-> strobe_sink;
    endproperty
    a_pol: assert property (p_pol) else $error("negative logic sense wrong");

    property p_bus;
        @(posedge clk) disable iff (!rst_n)
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer not in one cycle");

    c_update: cover property (@(posedge clk) disable iff (!rst_n) $fell(strb_q));
    c_hold: cover property (@(posedge clk) disable iff (!rst_n) hold_act && adc_done);
    c_print: cover property (@(posedge clk) disable iff (!rst_n) $rose(pc_q) && pos_logic);
endmodule

/* File: dv/bwp_reader.sv */
// far-side reader: closes contacts and takes data at the strobe end
module bwp_reader (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wanted contact states
    input wire logic hold,
    input wire logic pos,
    input wire logic [1:0] sel,
    // open-collector lines from the port
    input wire logic [19:0] bcd_sink,
    input wire logic minus_sink,
    input wire logic over_sink,
    input wire logic strobe_sink,
    // contacts, low while shorted to common_return
    output logic hold_pin_n,
    output logic logic_pin_n,
    output logic sel1_pin_n,
    output logic sel2_pin_n,
    // data taken at each strobe end
    output logic [21:0] cap_q,
    output logic [15:0] cnt_q
);
    logic prev_q;
    // contact closures
    assign hold_pin_n = !hold;
    assign logic_pin_n = !pos;
    assign sel1_pin_n = !sel[1];
    assign sel2_pin_n = !(sel == 2'h1 || sel == 2'h2);
    // take the lines on the trailing edge of the strobe
    always_ff @(posedge clk) begin
        prev_q <= strobe_sink ^ pos;
        if (!rst_n) begin
            cnt_q <= 16'h0000;
        end else if (prev_q && !(strobe_sink ^ pos)) begin
            cap_q <= {over_sink, minus_sink, bcd_sink} ^ {22{pos}};
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule

/* File: dv/tb_bcd_weight_parallel_output.sv */
module tb_bcd_weight_parallel_output;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STRB = 10;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, adc = 0, jd = 0, dov = 0;
    logic hold = 0, pos = 0, wreq, irq, hp_n, lp_n, s1_n, s2_n, mi, ov, pc, st;
    logic [1:0] sel = 2'h0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0000_0000, rdat, q, seed = 32'h3ae4_1d02;
    logic [19:0] mg [4] = '{default: 20'h0_0000};
    logic [3:0] ng = 4'h0;
    logic [19:0] bcd;
    logic [21:0] cap, b;
    logic [15:0] cap_cnt, c;
    int mismatches = 0, samples_checked = 0, cyc = 0, n;
    logic [4:0] ra [4] = '{bwp_pkg::OFS_CTRL, bwp_pkg::OFS_NET_OVER, bwp_pkg::OFS_MASK, 5'h1C};
    logic [31:0] rv [4] = '{32'h0000_0000, 32'(bwp_pkg::NET_OVER_RST), 32'h0000_0000, 32'h0000_0000};

    bwp_port #(.DEB_CYC(4), .STRB_CYC(STRB)) i_dut (
        .clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .irq(irq), .adc_done(adc), .judge_done(jd),
        .disp_mag(mg[0]), .disp_neg(ng[0]), .disp_over(dov), .net_mag(mg[1]), .net_neg(ng[1]),
        .gross_mag(mg[2]), .gross_neg(ng[2]), .tare_mag(mg[3]), .tare_neg(ng[3]),
        .hold_pin_n(hp_n), .logic_pin_n(lp_n), .sel1_pin_n(s1_n), .sel2_pin_n(s2_n),
        .bcd_sink(bcd), .minus_sink(mi), .over_sink(ov), .pc_sink(pc), .strobe_sink(st));
    bwp_reader i_rdr (
        .clk(clk), .rst_n(rst_n), .hold(hold), .pos(pos), .sel(sel), .bcd_sink(bcd),
        .minus_sink(mi), .over_sink(ov), .strobe_sink(st), .hold_pin_n(hp_n),
        .logic_pin_n(lp_n), .sel1_pin_n(s1_n), .sel2_pin_n(s2_n), .cap_q(cap), .cnt_q(cap_cnt));

    // clock and hang guard
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // low five decimal digits, four lines each
    function automatic logic [19:0] bcd5(input logic [19:0] v);
        logic [19:0] r;
        int x;
        x = int'(v) % 100000;
        for (int k = 0; k < 5; k++) begin
            r[4*k+:4] = 4'(x % 10);
            x = x / 10;
        end
        return r;
    endfunction

    // {over, minus, digits} of the selected value
    function automatic logic [21:0] expd();
        logic o;
        case (sel)
            2'h0: o = dov;
            2'h1: o = !ng[1] && mg[1] > bwp_pkg::NET_OVER_RST;
            2'h2: o = !ng[2] && mg[2] > bwp_pkg::GROSS_OVER_RST;
            default: o = !ng[3] && mg[3] > bwp_pkg::TARE_LIMIT;
        endcase
        return {o, ng[sel], bcd5(mg[sel])};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // contacts, then wait out the debounce
    task automatic pins(input logic h, input logic p, input logic [1:0] s);
        @(posedge clk);
        hold <= h;
        pos <= p;
        sel <= s;
        repeat (20) @(posedge clk);
    endtask

    task automatic pulse(input logic r);
        @(posedge clk);
        if (r) begin
            for (int k = 0; k < 4; k++) mg[k] <= rnd() % 2 ? 20'(rnd() % 100000) : 20'(rnd());
            ng <= 4'(rnd());
            dov <= 1'(rnd());
        end
        adc <= 1'b1;
        @(posedge clk);
        adc <= 1'b0;
    endtask

    task automatic conv(input logic r);
        logic [15:0] c0;
        int k;
        c0 = cap_cnt;
        k = 0;
        pulse(r);
        while (cap_cnt === c0 && k < 200) begin
            @(posedge clk);
            k++;
        end
        chk(32'(cap_cnt - c0), 1);
        chk(cap, expd());
        chk({ov, mi, bcd}, expd() ^ {22{pos}});
    endtask

    task automatic irqchk(input logic e);
        repeat (2) @(posedge clk);
        chk(irq, e);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({bcd, mi, ov, pc, st}, 0);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, ra[i], 32'h0000_0000);
            chk(q, rv[i]);
        end
        $display("test reset done");
        // every selection in both polarities
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                pins(1'b0, p[0], s[1:0]);
                repeat (4) conv(1'b1);
            end
        end
        $display("test select done");
        // each limit and one past it
        for (int s = 1; s < 4; s++) begin
            pins(1'b0, 1'b0, s[1:0]);
            for (int i = 0; i < 2; i++) begin
                @(posedge clk);
                mg[s] <= (s == 3 ? bwp_pkg::TARE_LIMIT : bwp_pkg::NET_OVER_RST) + 20'(i);
                ng <= 4'h0;
                conv(1'b0);
            end
        end
        $display("test limit done");
        // hold freezes data and stops strobes
        pins(1'b1, 1'b0, 2'h0);
        b = {ov, mi, bcd};
        c = cap_cnt;
        n = 0;
        pulse(1'b1);
        repeat (80) begin
            @(posedge clk);
            if (st === 1'b1) n++;
        end
        chk(32'(n), 0);
        chk({ov, mi, bcd}, b);
        chk(cap_cnt, c);
        pins(1'b0, 1'b0, 2'h0);
        $display("test hold done");
        // skip one of two conversions
        bus(1'b1, bwp_pkg::OFS_CTRL, 32'h0000_0001);
        c = cap_cnt;
        repeat (4) begin
            pulse(1'b1);
            repeat (50) @(posedge clk);
        end
        chk(32'(cap_cnt - c), 2);
        bus(1'b1, bwp_pkg::OFS_CTRL, 32'h0000_0000);
        $display("test skip done");
        // print pulse after judgment
        @(posedge clk);
        jd <= 1'b1;
        @(posedge clk);
        jd <= 1'b0;
        n = 0;
        repeat (20) begin
            if (pc === 1'b1) n++;
            @(posedge clk);
        end
        chk(32'(n), 32'(STRB));
        $display("test print done");
        // interrupt raise, mask, clear and port readback
        bus(1'b1, bwp_pkg::OFS_STATUS, 32'h0000_0007);
        bus(1'b1, bwp_pkg::OFS_MASK, 32'h0000_0001);
        irqchk(1'b0);
        conv(1'b1);
        irqchk(1'b1);
        bus(1'b0, bwp_pkg::OFS_PORT, 32'h0000_0000);
        chk(q, 32'(expd()));
        bus(1'b1, bwp_pkg::OFS_MASK, 32'h0000_0000);
        irqchk(1'b0);
        bus(1'b1, bwp_pkg::OFS_MASK, 32'h0000_0001);
        irqchk(1'b1);
        bus(1'b1, bwp_pkg::OFS_STATUS, 32'h0000_0001);
        irqchk(1'b0);
        $display("test irq done");
        wrap_up();
    end
endmodule
